// ==== verilog/vsg_source.sv ====
// Parallel video source: pixel clock, frame and line timing, controller reset and strap
`timescale 1ns/1ns
`default_nettype none
module vsg_source #(
	parameter int PCLK_HALF   = 2,
	parameter int LINE_KHZ    = 250,
	parameter int ACTIVE_PIXELS = 64,
	parameter int HSW         = 8,
	parameter int HBP         = 16,
	parameter int VSW         = 1,
	parameter int VBP         = 4,
	parameter int ACT_LINES   = 16,
	parameter int VFP         = 8,
	parameter int SRC_LINES   = 16,
	parameter int USED_LINES  = 16
) (
	input  wire logic                       mclk,              // System clock
	input  wire logic                       resetn,            // Synchronous reset, active low
	input  wire logic                       enable,            // Run frames while high
	input  wire logic                       reset_req,         // Pulse: reset the controller again
	output logic                            pix_clk,           // Pixel clock to the controller
	output logic                            frame_sync,        // Frame sync
	output logic                            line_sync,         // Line sync
	output logic                            active_data_valid, // Data valid strobe
	output logic [vsg_pkg::PIX_W-1:0]       pixel_data,        // Pixel data
	output logic                            reset_low_in,      // Controller reset, active low
	output logic                            osc_select_strap,  // Oscillator select strap
	output logic                            cfg_bad,           // Timing parameters break a limit
	output logic                            frame_start        // Pulse at each frame sync rise
);
	import vsg_pkg::*;

	localparam int PIX_MHZ   = MCLK_MHZ / (2 * PCLK_HALF);
	localparam int HTOTAL    = vsg_ceil_div(KHZ_PER_MHZ * PIX_MHZ, LINE_KHZ);
	localparam int DE_END    = HBP + ACTIVE_PIXELS;
	localparam int VTOTAL    = VBP + ACT_LINES + VFP;
	localparam int TVB_MIN   = TVB_BASE + vsg_max(TVB_SCALE,
		vsg_ceil_div(TVB_SCALE * SRC_LINES, USED_LINES));
	localparam logic BAD =
		(HSW < HSW_MIN) || (HSW > HSW_MAX) ||
		(HBP < HBP_MIN) ||
		(HTOTAL - DE_END < HFP_MIN) ||
		(HTOTAL - ACTIVE_PIXELS < HBP_MIN + HFP_MIN) ||
		(HSW >= HTOTAL) ||
		(VSW < VSW_MIN_LINES) || (VSW >= VTOTAL) ||
		(VBP < VBP_MIN_LINES) || (VFP < VFP_MIN_LINES) ||
		(VBP + VFP < TVB_MIN);
	localparam logic [CNT_W-1:0] HT_L  = CNT_W'(HTOTAL - 1);
	localparam logic [CNT_W-1:0] VT_L  = CNT_W'(VTOTAL - 1);
	localparam logic [CNT_W-1:0] HSW_C = CNT_W'(HSW);
	localparam logic [CNT_W-1:0] HBP_C = CNT_W'(HBP);
	localparam logic [CNT_W-1:0] DEE_C = CNT_W'(DE_END);
	localparam logic [CNT_W-1:0] VSW_C = CNT_W'(VSW);
	localparam logic [CNT_W-1:0] VBP_C = CNT_W'(VBP);
	localparam logic [CNT_W-1:0] VAE_C = CNT_W'(VBP + ACT_LINES);
	localparam logic [7:0] DIV_L = 8'(PCLK_HALF - 1);
	localparam logic [7:0] RST_L = 8'(RST_LOW_CYC - 1);

	// Pixel clock divider; sources change on the falling edge so the rising edge sees stable data
	logic [7:0] div_reg, div_next;
	logic       pclk_reg, pclk_next;
	logic       tick;

	always_comb begin
		div_next  = div_reg + 8'h01;
		pclk_next = pclk_reg;
		if (div_reg == DIV_L) begin
			div_next  = 8'h00;
			pclk_next = ~pclk_reg;
		end
	end

	assign tick = (div_reg == DIV_L) && pclk_reg; // R11

	always_ff @(posedge mclk) begin
		if (!resetn) begin
			div_reg  <= 8'h00;
			pclk_reg <= 1'b0;
		end else begin
			div_reg  <= div_next;
			pclk_reg <= pclk_next;
		end
	end

	// Sequencer: controller reset hold, then frame generation
	vsg_state_t       st_reg, st_next;
	logic [7:0]       rst_cnt_reg, rst_cnt_next;
	logic [CNT_W-1:0] h_reg, h_next, v_reg, v_next;
	logic             vs_reg, vs_next, hs_reg, hs_next, de_reg, de_next;
	logic [PIX_W-1:0] pd_reg, pd_next;
	logic             rstn_reg, rstn_next, fs_reg, fs_next;
	logic             active_line;

	assign active_line = (v_reg >= VBP_C) && (v_reg < VAE_C);

	always_comb begin
		st_next      = st_reg;
		rst_cnt_next = rst_cnt_reg;
		h_next       = h_reg;
		v_next       = v_reg;
		vs_next      = vs_reg;
		hs_next      = hs_reg;
		de_next      = de_reg;
		pd_next      = pd_reg;
		rstn_next    = rstn_reg;
		fs_next      = 1'b0;
		case (st_reg)
			VSG_HOLD: begin
				rstn_next = 1'b0;
				if (rst_cnt_reg == RST_L) begin // R9
					rstn_next = 1'b1;
					st_next   = VSG_IDLE;
				end else begin
					rst_cnt_next = rst_cnt_reg + 8'h01;
				end
			end
			VSG_IDLE: begin
				h_next = '0;
				v_next = '0;
				if (tick && enable && !BAD) begin
					st_next = VSG_RUN;
					vs_next = 1'b1;
					hs_next = 1'b1;
					fs_next = 1'b1;
				end
			end
			VSG_RUN: begin
				if (tick) begin
					h_next = (h_reg == HT_L) ? '0 : h_reg + 1'b1;
					if (h_reg == HT_L)
						v_next = (v_reg == VT_L) ? '0 : v_reg + 1'b1;
					if (h_reg == HT_L && v_reg == VT_L && !enable) begin
						st_next = VSG_IDLE;
						vs_next = 1'b0;
						hs_next = 1'b0;
						de_next = 1'b0;
					end else begin
						hs_next = (h_next < HSW_C);                       // R5
						vs_next = (v_next < VSW_C);                       // R1
						fs_next = (h_next == '0) && (v_next == '0);
						de_next = (h_next >= HBP_C) && (h_next < DEE_C)   // R6 R7 R8
							&& (v_next >= VBP_C) && (v_next < VAE_C);     // R2 R3 R4
						if (de_next)
							pd_next = pd_reg + 1'b1;
					end
				end
			end
			default: st_next = VSG_HOLD;
		endcase
		if (reset_req) begin
			st_next      = VSG_HOLD;
			rst_cnt_next = 8'h00;
			rstn_next    = 1'b0;
			vs_next      = 1'b0;
			hs_next      = 1'b0;
			de_next      = 1'b0;
			fs_next      = 1'b0;
		end
	end

	always_ff @(posedge mclk) begin
		if (!resetn) begin
			st_reg      <= VSG_HOLD;
			rst_cnt_reg <= 8'h00;
			h_reg       <= '0;
			v_reg       <= '0;
			vs_reg      <= 1'b0;
			hs_reg      <= 1'b0;
			de_reg      <= 1'b0;
			pd_reg      <= '0;
			rstn_reg    <= 1'b0;
			fs_reg      <= 1'b0;
		end else begin
			st_reg      <= st_next;
			rst_cnt_reg <= rst_cnt_next;
			h_reg       <= h_next;
			v_reg       <= v_next;
			vs_reg      <= vs_next;
			hs_reg      <= hs_next;
			de_reg      <= de_next;
			pd_reg      <= pd_next;
			rstn_reg    <= rstn_next;
			fs_reg      <= fs_next;
		end
	end

	assign pix_clk           = pclk_reg;
	assign frame_sync        = vs_reg;
	assign line_sync         = hs_reg;
	assign active_data_valid = de_reg;
	assign pixel_data        = pd_reg;
	assign reset_low_in      = rstn_reg;
	assign osc_select_strap  = STRAP_24MHZ; // R10
	assign cfg_bad           = BAD;         // R4 R8
	assign frame_start       = fs_reg;

	// Helper counters in pixel clocks, lines and system clocks for the checks below
	logic [CNT_W-1:0] since_hs, since_def, lines_vs, lines_act, rst_low;
	logic             seen_de, seen_act;

	always_ff @(posedge mclk) begin
		if (!resetn) begin
			since_hs  <= '0;
			since_def <= '0;
			lines_vs  <= '0;
			lines_act <= '0;
			rst_low   <= '0;
			seen_de   <= 1'b0;
			seen_act  <= 1'b0;
		end else begin
			rst_low <= reset_low_in ? '0 : rst_low + 1'b1;
			if (hs_next && !hs_reg) begin
				since_hs  <= '0;
				lines_vs  <= (vs_next && !vs_reg) ? '0 : lines_vs + 1'b1;
				lines_act <= lines_act + 1'b1;
				if (active_line)
					lines_act <= '0;
				seen_act <= seen_act | active_line;
			end else if (tick) begin
				since_hs <= since_hs + 1'b1;
			end
			if (de_reg && !de_next) begin
				since_def <= '0;
				seen_de   <= 1'b1;
			end else if (tick) begin
				since_def <= since_def + 1'b1;
			end
		end
	end

	a_hsync_width: assert property (@(posedge mclk) disable iff (!resetn) // R5
		$fell(line_sync) && st_reg == VSG_RUN |->
			since_hs >= CNT_W'(HSW_MIN) && since_hs <= CNT_W'(HSW_MAX))
		else $error("line sync pulse width out of range");

	a_back_porch: assert property (@(posedge mclk) disable iff (!resetn) // R6
		$rose(active_data_valid) |-> since_hs >= CNT_W'(HBP_MIN))
		else $error("horizontal back porch too short");

	a_front_porch: assert property (@(posedge mclk) disable iff (!resetn) // R7
		$rose(line_sync) && seen_de |-> since_def >= CNT_W'(HFP_MIN))
		else $error("horizontal front porch too short");

	a_vsync_width: assert property (@(posedge mclk) disable iff (!resetn) // R1
		$fell(frame_sync) && st_reg == VSG_RUN |-> lines_vs >= CNT_W'(VSW_MIN_LINES))
		else $error("frame sync shorter than one line");

	a_vert_back: assert property (@(posedge mclk) disable iff (!resetn) // R2
		$rose(line_sync) && v_reg == VBP_C |-> lines_vs >= CNT_W'(VBP_MIN_LINES))
		else $error("vertical back porch too short");

	a_vert_front: assert property (@(posedge mclk) disable iff (!resetn) // R3
		$rose(frame_sync) && seen_act |-> lines_act >= CNT_W'(VFP_MIN_LINES))
		else $error("vertical front porch too short");

	a_blank_cfg: assert property (@(posedge mclk) disable iff (!resetn) // R4 R8
		$rose(frame_sync) |-> !cfg_bad ##1 frame_start == 1'b0)
		else $error("frames started with bad blanking settings");

	a_reset_hold: assert property (@(posedge mclk) disable iff (!resetn) // R9
		$rose(reset_low_in) |-> rst_low >= CNT_W'(RST_LOW_CYC))
		else $error("controller reset released too early");

	a_strap_low: assert property (@(posedge mclk) disable iff (!resetn) // R10
		reset_low_in |-> osc_select_strap == STRAP_24MHZ)
		else $error("oscillator strap not low");

	a_edge_data: assert property (@(posedge mclk) disable iff (!resetn) // R11
		$changed(active_data_valid) && st_reg != VSG_HOLD |-> $past(pclk_reg) && !pclk_reg)
		else $error("data valid moved away from falling pixel clock edge");
endmodule // vsg_source
`default_nettype wire

// ==== verilog/vsg_pkg.sv ====
// Constants and timing limits for the parallel video source that drives the display controller
// Behaviour
// R1: Frame sync stays high for at least one whole line time in every frame.
// R2: Two or more line times pass from frame sync rising to the first active line sync.
// R3: At least one line passes from the line sync after the last active line to frame sync.
// R4: Vertical blanking is at least 6 plus 6 times the larger of 1 and source over used lines.
// R5: Each line sync high pulse lasts from 4 to 128 pixel clocks inclusive.
// R6: At least 4 pixel clocks pass from line sync rising to data valid rising.
// R7: At least 8 pixel clocks pass from data valid falling to the next line sync rising.
// R8: Line length in pixel clocks, rounded up, less active pixels must cover both porches.
// R9: The controller reset is held low for at least 1.25 microseconds on every assertion.
// R10: The oscillator select strap is held low so the 24 MHz setting is chosen at power-up.
// R11: The controller captures sync, valid and data on the rising pixel clock edge after reset.
// R12: The controller counts blanking and flags any width or porch outside its limits.
`default_nettype none
package vsg_pkg;
	localparam int MCLK_MHZ       = 100;
	localparam int RST_LOW_NS     = 1250;
	localparam int RST_LOW_CYC    = (RST_LOW_NS * MCLK_MHZ + 999) / 1000;
	localparam int VSW_MIN_LINES  = 1;
	localparam int VBP_MIN_LINES  = 2;
	localparam int VFP_MIN_LINES  = 1;
	localparam int TVB_BASE       = 6;
	localparam int TVB_SCALE      = 6;
	localparam int HSW_MIN        = 4;
	localparam int HSW_MAX        = 128;
	localparam int HBP_MIN        = 4;
	localparam int HFP_MIN        = 8;
	localparam int KHZ_PER_MHZ    = 1000;
	localparam int PIX_W          = 24;
	localparam int CNT_W          = 16;
	localparam logic STRAP_24MHZ  = 1'b0;

	typedef enum logic [1:0] {VSG_HOLD, VSG_IDLE, VSG_RUN} vsg_state_t;

	function automatic int vsg_ceil_div(input int num, input int den);
		return (num + den - 1) / den;
	endfunction

	function automatic int vsg_max(input int a, input int b);
		return (a > b) ? a : b;
	endfunction
endpackage
`default_nettype wire

// ==== testbench/vsg_ctrl_model.sv ====
// Controller model: samples the video port and flags timing faults
`timescale 1ns/1ns
`default_nettype none
module vsg_ctrl_model #(
	parameter int TVB_MIN = 12
) (
	input  wire logic                      pix_clk,      // Pixel clock
	input  wire logic                      reset_low_in, // Reset, active low
	input  wire logic                      strap,        // Oscillator strap
	input  wire logic                      fs,           // Frame sync
	input  wire logic                      ls,           // Line sync
	input  wire logic                      dv,           // Data valid
	input  wire logic [vsg_pkg::PIX_W-1:0] pd,           // Pixel data
	output var  logic [7:0]                viol,         // Sticky faults
	output var  int                        frames,       // Frames seen
	output var  int                        act_lines,    // Active lines, last frame
	output var  int                        act_now,      // Active lines, this frame
	output var  int                        line_len,     // Clocks per line
	output var  int                        line_px,      // Pixels, last line
	output var  int                        hsw_len       // Line sync width
);
	import vsg_pkg::*;
	logic fq, lq, dq, had, seen, first, dok;
	int pc, fc, lc, post, hf, px;
	logic [PIX_W-1:0] last;
	realtime t0;
	initial viol = 8'h00;
	always @(negedge reset_low_in) t0 = $realtime;
	always @(posedge reset_low_in) begin
		if ($realtime - t0 < RST_LOW_NS) viol[6] = 1'b1;
		if (strap !== STRAP_24MHZ) viol[7] = 1'b1;
	end
	// Capture on the rising pixel clock edge
	always @(posedge pix_clk or negedge reset_low_in) begin
		if (!reset_low_in) begin
			viol[5:0] = 6'h00;
			{fq, lq, dq, had, seen, first, dok} = 7'h00;
			pc = 0;
			hf = HFP_MIN;
		end else begin
			pc++;
			fc++;
			hf++;
			if (ls && !lq) begin
				if (hf < HFP_MIN) viol[2] = 1'b1;
				line_len = pc;
				pc = 0;
				lc++;
				post = had ? 0 : post + 1;
				had = 1'b0;
			end
			if (lq && !ls) begin
				hsw_len = pc;
				if (pc < HSW_MIN || pc > HSW_MAX) viol[0] = 1'b1;
			end
			if (fs && !fq) begin
				if (seen && post < VFP_MIN_LINES) viol[4] = 1'b1;
				fc = 0;
				lc = 0;
				frames++;
				act_lines = act_now;
				act_now = 0;
				first = 1'b1;
			end
			if (fq && !fs && fc < line_len) viol[3] = 1'b1;
			if (dv && !dq) begin
				if (pc < HBP_MIN) viol[1] = 1'b1;
				if (first && lc < VBP_MIN_LINES) viol[4] = 1'b1;
				if (first && seen && post < TVB_MIN) viol[4] = 1'b1;
				first = 1'b0;
				seen = 1'b1;
				had = 1'b1;
				act_now++;
				px = 0;
			end
			if (dv) begin
				if (dok && pd !== last + 1'b1) viol[5] = 1'b1;
				last = pd;
				dok = 1'b1;
				px++;
			end
			if (dq && !dv) begin
				hf = 0;
				line_px = px;
			end
			fq = fs;
			lq = ls;
			dq = dv;
		end
	end
endmodule // vsg_ctrl_model
`default_nettype wire

// ==== testbench/vsg_source_tb.sv ====
// Self-checking bench for the parallel video source
`timescale 1ns/1ns
`default_nettype none
module vsg_source_tb;
	import vsg_pkg::*;
	localparam int ACT_PIX_S = 64;
	// Blanking of VBP plus this is below the minimum, so no frame may start
	localparam int VFP_BAD = 1;
	localparam int HSW_S  = 8;
	localparam int ACT_S  = 16;
	localparam int HTOT   = (KHZ_PER_MHZ * (MCLK_MHZ / 4) + 249) / 250;
	localparam int TVB_S  = TVB_BASE + TVB_SCALE;
	logic mclk = 1'b0, resetn = 1'b0, enable = 1'b0, reset_req = 1'b0;
	logic pix_clk, fsy, lsy, dv, rl, strap, cfg_bad, fst;
	logic [PIX_W-1:0] pd;
	logic [7:0] viol;
	logic cfg_bad_b, fsy_b;
	logic bad_framed = 1'b0;
	int frames, act_lines, act_now, line_len, line_px, hsw_len;
	int fails, compares, cyc, n, k;
	always #5 mclk = ~mclk;
	vsg_source #(.ACTIVE_PIXELS(ACT_PIX_S), .HSW(HSW_S), .ACT_LINES(ACT_S)) u_vsg_source (
		.mclk(mclk), .resetn(resetn), .enable(enable), .reset_req(reset_req),
		.pix_clk(pix_clk), .frame_sync(fsy), .line_sync(lsy), .active_data_valid(dv),
		.pixel_data(pd), .reset_low_in(rl), .osc_select_strap(strap), .cfg_bad(cfg_bad),
		.frame_start(fst));
	vsg_source #(.VFP(VFP_BAD)) u_vsg_source_bad (
		.mclk(mclk), .resetn(resetn), .enable(enable), .reset_req(reset_req),
		.pix_clk(), .frame_sync(fsy_b), .line_sync(), .active_data_valid(),
		.pixel_data(), .reset_low_in(), .osc_select_strap(), .cfg_bad(cfg_bad_b),
		.frame_start());
	always @(posedge mclk) if (fsy_b === 1'b1) bad_framed <= 1'b1;
	vsg_ctrl_model #(.TVB_MIN(TVB_S)) u_vsg_ctrl_model (.pix_clk(pix_clk), .reset_low_in(rl),
		.strap(strap), .fs(fsy), .ls(lsy), .dv(dv), .pd(pd), .viol(viol), .frames(frames),
		.act_lines(act_lines), .act_now(act_now), .line_len(line_len), .line_px(line_px),
		.hsw_len(hsw_len));
	task automatic chk(input logic ok, input string m);
		compares++;
		if (ok !== 1'b1) begin
			fails++;
			$display("[ERR] %0t %s", $time, m);
		end
	endtask
	task automatic finish_test;
		$display("compares=%0d fails=%0d", compares, fails);
		if (fails == 0 && compares > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	task automatic wait_fs;
		n = 0;
		@(negedge mclk);
		while (fst !== 1'b1 && n < 15000) begin
			@(negedge mclk);
			n++;
		end
		chk(n < 15000, "no frame start");
	endtask
	task automatic t_reset;
		@(posedge mclk);
		@(negedge mclk);
		chk({pix_clk, fsy, lsy, dv, rl, fst} === 6'h00, "outputs busy in reset");
		repeat (2) @(posedge mclk);
		resetn <= 1'b1;
		n = 0;
		@(negedge mclk);
		while (rl === 1'b0 && n < 200) begin
			@(negedge mclk);
			n++;
		end
		chk(n == RST_LOW_CYC, "controller reset width");
		chk(strap === 1'b0 && cfg_bad === 1'b0, "strap or config");
	endtask
	task automatic t_frames;
		@(posedge mclk);
		enable <= 1'b1;
		repeat (3) wait_fs;
		repeat (8) @(negedge mclk);
		chk(viol === 8'h00, "timing fault");
		chk(line_len === HTOT && line_px === ACT_PIX_S, "line shape");
		chk(hsw_len === HSW_S && act_lines === ACT_S, "sync or lines");
		chk(frames === 3, "frame count");
	endtask
	task automatic t_rreq;
		repeat (3000) @(posedge mclk);
		reset_req <= 1'b1;
		@(posedge mclk);
		reset_req <= 1'b0;
		@(negedge mclk);
		chk({rl, fsy, lsy, dv} === 4'h0, "reset request ignored");
		repeat (2) wait_fs;
		repeat (8) @(negedge mclk);
		chk(viol === 8'h00 && act_lines === ACT_S, "recovery after reset");
	endtask
	task automatic t_drop;
		wait_fs;
		repeat (2000) @(posedge mclk);
		enable <= 1'b0;
		k = 0;
		repeat (15000) begin
			@(negedge mclk);
			if (fst === 1'b1) k++;
		end
		chk(k == 0 && fsy === 1'b0, "frame after disable");
		chk(act_now === ACT_S && viol === 8'h00, "frame cut short");
		chk(cfg_bad_b === 1'b1 && bad_framed === 1'b0, "bad blanking not refused");
	endtask
	always @(posedge mclk) begin
		cyc++;
		if (cyc == 90000) begin
			fails++;
			$display("[ERR] %0t timeout", $time);
			finish_test;
		end
	end
	initial begin
		t_reset;
		t_frames;
		t_rreq;
		t_drop;
		finish_test;
	end
endmodule // vsg_source_tb
`default_nettype wire
